// ===== tb/qdsc_host_model.sv
// Host side of the three-wire link: frame select, serial clock and data
`default_nettype none
module qdsc_host_model (
  output var logic sclk,
  output var logic sin,
  output var logic fs_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    sin = 1'b0;
    fs_n = 1'b1;
  end
  // Clock stands low between frames; offset keeps edges clear of the core clock
  task automatic send(input logic [15:0] w, input int nb, input int extra);
    int i;
    #13;
    fs_n = 1'b0;
    #30;
    for (i = 0; i < nb + extra; i++) begin
      sin = (i < 16) ? w[15-i] : i[0];
      sclk = 1'b1;
      #40;
      sclk = 1'b0;
      #40;
    end
  endtask : send
  // Released data line shows the inverse so a stale bit cannot pass as valid
  task automatic release_sel();
    fs_n = 1'b1;
    sin = ~sin;
    #100;
  endtask : release_sel
endmodule : qdsc_host_model
`default_nettype wire

// ===== tb/tb_quad_dac_serial_control.sv
// Self-checking bench for the quad DAC serial control block
`default_nettype none
module tb_quad_dac_serial_control;
  import qdsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic sclk, sin, fs_n;
  logic [11:0] a, b, c, d;
  logic [11:0] a8, b8, c8, d8;
  logic oe, run, ibuf, done;
  int mismatches = 0;
  int n_checks = 0;
  always #25 core_clk = ~core_clk;
  qdsc_host_model u_host (.sclk(sclk), .sin(sin), .fs_n(fs_n));
  qdsc_ctrl #(.RESOLUTION(12), .WAKE_COUNT(5)) u_dut (
    .CORE_CLK(core_clk), .RESET(reset), .SERIAL_CLOCK(sclk), .SERIAL_IN(sin),
    .FRAME_SELECT_N(fs_n), .DAC_CODE_A(a), .DAC_CODE_B(b), .DAC_CODE_C(c),
    .DAC_CODE_D(d), .OUTPUT_ENABLE(oe), .RUN_NOT_SLEEP(run),
    .INPUT_BUFFER_ON(ibuf), .FRAME_DONE(done)
  );
  // Eight-bit variant on the same link, so the dropped low bits are seen
  qdsc_ctrl #(.RESOLUTION(8), .WAKE_COUNT(5)) u_dut8 (
    .CORE_CLK(core_clk), .RESET(reset), .SERIAL_CLOCK(sclk), .SERIAL_IN(sin),
    .FRAME_SELECT_N(fs_n), .DAC_CODE_A(a8), .DAC_CODE_B(b8), .DAC_CODE_C(c8),
    .DAC_CODE_D(d8), .OUTPUT_ENABLE(), .RUN_NOT_SLEEP(),
    .INPUT_BUFFER_ON(), .FRAME_DONE()
  );
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk_code(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_code
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_all(input logic [11:0] ea, eb, ec, ed);
    chk_code(a, ea);
    chk_code(b, eb);
    chk_code(c, ec);
    chk_code(d, ed);
  endtask : chk_all
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle
  task automatic frame(input logic [15:0] w, input int nb);
    u_host.send(w, nb, 0);
    u_host.release_sel();
    settle(20);
  endtask : frame
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    settle(2);
    chk_all(12'h000, 12'h000, 12'h000, 12'h000);
    chk_bit(oe, 1'b1);
    chk_bit(run, 1'b1);
    frame(16'h3123, 16);
    chk_all(12'h000, 12'h000, 12'h000, 12'h000);
    frame(16'h7456, 16);
    chk_all(12'h000, 12'h000, 12'h000, 12'h000);
    frame(16'hAABC, 16);
    chk_all(12'h123, 12'h456, 12'hABC, 12'h000);
    chk_code(c8, 12'hAB0);
    chk_code(a8, 12'h120);
    // Short frame with load-all would set D if it were not dropped
    frame(16'hE555, 12);
    chk_all(12'h123, 12'h456, 12'hABC, 12'h000);
    // Extra clocks after the 16th edge, select still low
    u_host.send(16'hEFFF, 16, 4);
    settle(20);
    chk_bit(done, 1'b1);
    chk_bit(ibuf, 1'b0);
    chk_all(12'h123, 12'h456, 12'hABC, 12'hFFF);
    u_host.release_sel();
    settle(20);
    chk_bit(done, 1'b0);
    frame(16'h1777, 16);
    chk_bit(oe, 1'b0);
    chk_bit(run, 1'b0);
    chk_all(12'h123, 12'h456, 12'hABC, 12'hFFF);
    frame(16'h6001, 16);
    chk_bit(oe, 1'b1);
    chk_bit(run, 1'b1);
    chk_all(12'h777, 12'h001, 12'hABC, 12'hFFF);
    chk_code(a8, 12'h770);
    chk_code(b8, 12'h000);
    chk_code(d8, 12'hFF0);
    report_and_stop();
  end
endmodule : tb_quad_dac_serial_control
`default_nettype wire

// ===== verilog/qdsc_code_mem.sv
// Four-entry code store with registered read ports for all entries
`default_nettype none
module qdsc_code_mem
  import qdsc_pkg::*;
#(
  parameter int WIDTH = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [NUM_CHAN*WIDTH-1:0] rd_all
);
  logic [WIDTH-1:0] mem_reg [NUM_CHAN];
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CHAN; i++) mem_reg[i] <= WIDTH'(CODE_RESET);
    end else if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_all <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) rd_all[i*WIDTH +: WIDTH] <= mem_reg[i];
    end
  end
endmodule : qdsc_code_mem
`default_nettype wire

// ===== verilog/qdsc_ctrl.sv
// Serial front end, double-buffered code registers and power control of the quad DAC
`default_nettype none
module qdsc_ctrl
  import qdsc_pkg::*;
#(
  parameter int RESOLUTION = 12,
  parameter int WAKE_COUNT = WAKE_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic SERIAL_CLOCK,
  input wire logic SERIAL_IN,
  input wire logic FRAME_SELECT_N,
  output logic [DATA_BITS_MAX-1:0] DAC_CODE_A,
  output logic [DATA_BITS_MAX-1:0] DAC_CODE_B,
  output logic [DATA_BITS_MAX-1:0] DAC_CODE_C,
  output logic [DATA_BITS_MAX-1:0] DAC_CODE_D,
  output logic OUTPUT_ENABLE,
  output logic RUN_NOT_SLEEP,
  output logic INPUT_BUFFER_ON,
  output logic FRAME_DONE
);
  // Link domain: negedge SERIAL_CLOCK. Async clear from select high is safe since
  // it only sets constants; abort follows from it, buffer gating from the select synchronized in the core.
  logic [15:0] shift_reg;
  logic [4:0] count_reg;
  logic [15:0] frame_reg;
  logic frame_tgl_reg;
  wire link_clear = FRAME_SELECT_N;
  wire link_active = (count_reg < 5'(FRAME_BITS));

  always_ff @(negedge SERIAL_CLOCK or posedge link_clear) begin
    if (link_clear) begin
      count_reg <= '0;
    end else if (link_active) begin
      count_reg <= count_reg + 5'd1;
    end
  end

  always_ff @(negedge SERIAL_CLOCK) begin
    if (!FRAME_SELECT_N && link_active) begin
      shift_reg <= {shift_reg[14:0], SERIAL_IN};
    end
  end

  // Frame word and toggle stand still after the 16th edge, so the core samples safely
  wire last_bit = !FRAME_SELECT_N && (count_reg == 5'(FRAME_BITS - 1));
  always_ff @(negedge SERIAL_CLOCK or posedge RESET) begin
    if (RESET) begin
      frame_reg <= '0;
      frame_tgl_reg <= 1'b0;
    end else if (last_bit) begin
      frame_reg <= {shift_reg[14:0], SERIAL_IN};
      frame_tgl_reg <= ~frame_tgl_reg;
    end
  end

  // Core domain
  logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
  logic sel_s1_reg, sel_s2_reg;
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
      sel_s1_reg <= 1'b1;
      sel_s2_reg <= 1'b1;
    end else begin
      tgl_s1_reg <= frame_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
      sel_s1_reg <= FRAME_SELECT_N;
      sel_s2_reg <= sel_s1_reg;
    end
  end
  wire frame_evt = tgl_s2_reg ^ tgl_s3_reg;

  function automatic logic [DATA_BITS_MAX-1:0] trim_code(input logic [DATA_BITS_MAX-1:0] raw);
    logic [DATA_BITS_MAX-1:0] mask;
    mask = '1;
    mask = mask << (DATA_BITS_MAX - RESOLUTION);
    trim_code = raw & mask;
  endfunction : trim_code

  wire [1:0] frame_chan = {frame_reg[CHAN_HI_POS], frame_reg[CHAN_LO_POS]};
  wire frame_run = frame_reg[RUN_POS];
  wire frame_load_all_n = frame_reg[LOAD_ALL_POS];
  wire [DATA_BITS_MAX-1:0] frame_code = trim_code(frame_reg[DATA_MSB_POS:0]);

  // Input registers live in the memory; the write happens on the frame event
  logic [NUM_CHAN*DATA_BITS_MAX-1:0] input_all;
  qdsc_code_mem #(.WIDTH(DATA_BITS_MAX)) u_mem (
    .clk(CORE_CLK),
    .rst(RESET),
    .wr_en(frame_evt),
    .wr_addr(frame_chan),
    .wr_data(frame_code),
    .rd_all(input_all)
  );

  // Load-all waits two cycles so the memory's registered read shows the new word
  logic [1:0] load_pipe_reg;
  logic [NUM_CHAN-1:0] dirty_reg;
  logic [DATA_BITS_MAX-1:0] dac_reg [NUM_CHAN];
  wire load_now = load_pipe_reg[1];
  wire [NUM_CHAN-1:0] chan_hit = frame_evt ? (4'b0001 << frame_chan) : 4'b0000;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      load_pipe_reg <= '0;
    end else begin
      load_pipe_reg <= {load_pipe_reg[0], frame_evt & ~frame_load_all_n};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      dirty_reg <= '0;
    end else begin
      // A new write wins over the clear from an earlier load
      dirty_reg <= (dirty_reg & ~({NUM_CHAN{load_now}})) | chan_hit;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      for (int i = 0; i < NUM_CHAN; i++) dac_reg[i] <= CODE_RESET;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (load_now && dirty_reg[i]) begin
          dac_reg[i] <= input_all[i*DATA_BITS_MAX +: DATA_BITS_MAX];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      DAC_CODE_A <= CODE_RESET;
      DAC_CODE_B <= CODE_RESET;
      DAC_CODE_C <= CODE_RESET;
      DAC_CODE_D <= CODE_RESET;
    end else begin
      DAC_CODE_A <= dac_reg[0];
      DAC_CODE_B <= dac_reg[1];
      DAC_CODE_C <= dac_reg[2];
      DAC_CODE_D <= dac_reg[3];
    end
  end

  // Power control; registers are never touched here
  localparam int WAKE_W = $clog2(WAKE_COUNT + 1) + 1;
  qdsc_pwr_type pwr_reg, pwr_next;
  logic [WAKE_W-1:0] wake_reg;
  wire wake_done = (wake_reg >= WAKE_W'(WAKE_COUNT - 1));

  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      QDSC_IDLE: pwr_next = QDSC_RUN_ON;
      QDSC_RUN_ON: if (frame_evt && !frame_run) pwr_next = QDSC_SLEEP;
      QDSC_SLEEP: if (frame_evt && frame_run) pwr_next = QDSC_WAKE;
      QDSC_WAKE: begin
        if (frame_evt && !frame_run) pwr_next = QDSC_SLEEP;
        else if (wake_done) pwr_next = QDSC_RUN_ON;
      end
      default: pwr_next = QDSC_RUN_ON;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pwr_reg <= QDSC_IDLE;
      wake_reg <= '0;
    end else begin
      pwr_reg <= pwr_next;
      wake_reg <= (pwr_reg == QDSC_WAKE) ? wake_reg + WAKE_W'(1) : '0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      OUTPUT_ENABLE <= RUN_RESET;
      RUN_NOT_SLEEP <= RUN_RESET;
      INPUT_BUFFER_ON <= 1'b0;
      FRAME_DONE <= 1'b0;
    end else begin
      OUTPUT_ENABLE <= (pwr_next == QDSC_RUN_ON) || (pwr_next == QDSC_IDLE);
      RUN_NOT_SLEEP <= (pwr_next != QDSC_SLEEP);
      INPUT_BUFFER_ON <= !sel_s2_reg && !frame_evt && !(INPUT_BUFFER_ON == 1'b0 && FRAME_DONE);
      FRAME_DONE <= frame_evt ? 1'b1 : (sel_s2_reg ? 1'b0 : FRAME_DONE);
    end
  end

  // Assertions: DAC register loading
  a_load_updates_dac: assert property (@(posedge CORE_CLK) disable iff (RESET)
    load_now && dirty_reg[0] |=> dac_reg[0] == $past(input_all[DATA_BITS_MAX-1:0]))
    else $error("DAC register A missed load-all");
  a_load_dac_b: assert property (@(posedge CORE_CLK) disable iff (RESET)
    load_now && dirty_reg[1] |=> dac_reg[1] == $past(input_all[2*DATA_BITS_MAX-1:DATA_BITS_MAX]))
    else $error("DAC register B missed load-all");
  a_load_dac_c: assert property (@(posedge CORE_CLK) disable iff (RESET)
    load_now && dirty_reg[2] |=> dac_reg[2] == $past(input_all[3*DATA_BITS_MAX-1:2*DATA_BITS_MAX]))
    else $error("DAC register C missed load-all");
  a_load_dac_d: assert property (@(posedge CORE_CLK) disable iff (RESET)
    load_now && dirty_reg[3] |=> dac_reg[3] == $past(input_all[4*DATA_BITS_MAX-1:3*DATA_BITS_MAX]))
    else $error("DAC register D missed load-all");
  a_no_load_holds: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !load_now |=> $stable(dac_reg[1]))
    else $error("DAC register B changed without load-all");
  a_clean_not_loaded: assert property (@(posedge CORE_CLK) disable iff (RESET)
    load_now && !dirty_reg[2] |=> $stable(dac_reg[2]))
    else $error("Unwritten channel reloaded");
  a_clean_keep_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    load_now && !dirty_reg[0] |=> $stable(dac_reg[0]))
    else $error("Unwritten channel A reloaded");
  a_clean_keep_b: assert property (@(posedge CORE_CLK) disable iff (RESET)
    load_now && !dirty_reg[1] |=> $stable(dac_reg[1]))
    else $error("Unwritten channel B reloaded");
  a_clean_keep_d: assert property (@(posedge CORE_CLK) disable iff (RESET)
    load_now && !dirty_reg[3] |=> $stable(dac_reg[3]))
    else $error("Unwritten channel D reloaded");
  a_load_follows: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt && !frame_load_all_n |=> ##1 load_now)
    else $error("Load-all frame did not start a load");
  a_single_no_load: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt && frame_load_all_n |=> ##1 !load_now)
    else $error("Single write started a load");

  // Written-since-load flags; a write in the load cycle must survive the clear
  a_dirty_set_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt && frame_chan == 2'b00 |=> dirty_reg[0])
    else $error("Channel A write not remembered");
  a_dirty_set_b: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt && frame_chan == 2'b01 |=> dirty_reg[1])
    else $error("Channel B write not remembered");
  a_dirty_set_c: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt && frame_chan == 2'b10 |=> dirty_reg[2])
    else $error("Channel C write not remembered");
  a_dirty_set_d: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt && frame_chan == 2'b11 |=> dirty_reg[3])
    else $error("Channel D write not remembered");
  a_dirty_clear: assert property (@(posedge CORE_CLK) disable iff (RESET)
    load_now && !frame_evt |=> dirty_reg == '0)
    else $error("Write flags not cleared by load");

  // Input registers: only a completed frame writes, and only its own channel
  a_chan_write: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt && frame_chan == 2'b01 |=> ##1 input_all[2*DATA_BITS_MAX-1:DATA_BITS_MAX] == $past(frame_code, 2))
    else $error("Channel B input register not written");
  a_write_chan_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt && frame_chan == 2'b00 |=> ##1 input_all[DATA_BITS_MAX-1:0] == $past(frame_code, 2))
    else $error("Channel A input register not written");
  a_write_chan_c: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt && frame_chan == 2'b10 |=> ##1 input_all[3*DATA_BITS_MAX-1:2*DATA_BITS_MAX] == $past(frame_code, 2))
    else $error("Channel C input register not written");
  a_write_chan_d: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt && frame_chan == 2'b11 |=> ##1 input_all[4*DATA_BITS_MAX-1:3*DATA_BITS_MAX] == $past(frame_code, 2))
    else $error("Channel D input register not written");
  a_other_chan_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt && frame_chan != 2'b00 |=> ##1 $stable(input_all[DATA_BITS_MAX-1:0]))
    else $error("Write to another channel changed A");
  a_mem_only_frame: assert property (@(posedge CORE_CLK) disable iff (RESET)
    !frame_evt |=> ##1 $stable(input_all))
    else $error("Input register changed without a full frame");

  // Output codes
  a_code_trimmed: assert property (@(posedge CORE_CLK) disable iff (RESET)
    ((DAC_CODE_A | DAC_CODE_B | DAC_CODE_C | DAC_CODE_D) & ~trim_code('1)) == '0)
    else $error("Ignored low data bits reached an output");
  a_out_follow_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
    1'b1 |=> DAC_CODE_A == $past(dac_reg[0]))
    else $error("Output A does not follow its DAC register");
  a_out_follow_b: assert property (@(posedge CORE_CLK) disable iff (RESET)
    1'b1 |=> DAC_CODE_B == $past(dac_reg[1]))
    else $error("Output B does not follow its DAC register");
  a_out_follow_c: assert property (@(posedge CORE_CLK) disable iff (RESET)
    1'b1 |=> DAC_CODE_C == $past(dac_reg[2]))
    else $error("Output C does not follow its DAC register");
  a_out_follow_d: assert property (@(posedge CORE_CLK) disable iff (RESET)
    1'b1 |=> DAC_CODE_D == $past(dac_reg[3]))
    else $error("Output D does not follow its DAC register");

  // Power state; registers keep their contents in every state
  a_sleep_hiz: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt && !frame_run |=> ##1 !OUTPUT_ENABLE)
    else $error("Outputs not off after sleep frame");
  a_sleep_keeps: assert property (@(posedge CORE_CLK) disable iff (RESET)
    pwr_reg == QDSC_SLEEP && !load_now |=> $stable(dac_reg[3]))
    else $error("Sleep altered DAC register");
  a_run_flag: assert property (@(posedge CORE_CLK) disable iff (RESET)
    RUN_NOT_SLEEP == (pwr_reg != QDSC_SLEEP))
    else $error("Run flag disagrees with power state");
  a_oe_state: assert property (@(posedge CORE_CLK) disable iff (RESET)
    OUTPUT_ENABLE == (pwr_reg == QDSC_RUN_ON || pwr_reg == QDSC_IDLE))
    else $error("Output enable disagrees with power state");
  a_idle_leaves: assert property (@(posedge CORE_CLK) disable iff (RESET)
    pwr_reg == QDSC_IDLE |=> pwr_reg == QDSC_RUN_ON)
    else $error("Power state did not start in normal operation");
  a_sleep_entry: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt && !frame_run |=> pwr_reg == QDSC_SLEEP)
    else $error("Sleep frame did not power down");
  a_sleep_stays: assert property (@(posedge CORE_CLK) disable iff (RESET)
    pwr_reg == QDSC_SLEEP && !frame_evt |=> pwr_reg == QDSC_SLEEP)
    else $error("Power-down left without a frame");
  a_wake_entry: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt && frame_run && pwr_reg == QDSC_SLEEP |=> pwr_reg == QDSC_WAKE)
    else $error("Run frame did not start wake-up");
  a_wake_time: assert property (@(posedge CORE_CLK) disable iff (RESET)
    $rose(pwr_reg == QDSC_WAKE) |-> ##[1:300] pwr_reg != QDSC_WAKE)
    else $error("Wake delay too long");
  a_wake_bound: assert property (@(posedge CORE_CLK) disable iff (RESET)
    pwr_reg == QDSC_WAKE |-> wake_reg < WAKE_W'(WAKE_COUNT))
    else $error("Wake counter overran");
  a_wake_exit: assert property (@(posedge CORE_CLK) disable iff (RESET)
    pwr_reg == QDSC_WAKE && wake_done && !frame_evt |=> OUTPUT_ENABLE)
    else $error("Outputs not on after wake delay");

  // Frame status and input gating as seen from the core
  a_done_set: assert property (@(posedge CORE_CLK) disable iff (RESET)
    frame_evt |=> FRAME_DONE)
    else $error("Frame completion not flagged");
  a_buf_off_done: assert property (@(posedge CORE_CLK) disable iff (RESET)
    FRAME_DONE |-> !INPUT_BUFFER_ON)
    else $error("Input buffers on after a full frame");
  a_buf_sel_high: assert property (@(posedge CORE_CLK) disable iff (RESET)
    sel_s2_reg |=> !INPUT_BUFFER_ON)
    else $error("Input buffers on with select high");

  // Link domain
  a_count_limit: assert property (@(negedge SERIAL_CLOCK) disable iff (FRAME_SELECT_N)
    count_reg <= 5'(FRAME_BITS))
    else $error("Bit count passed frame length");
  a_link_hold: assert property (@(negedge SERIAL_CLOCK) disable iff (FRAME_SELECT_N)
    !link_active |=> $stable(shift_reg))
    else $error("Shift register moved after the last bit");
  a_link_commit: assert property (@(negedge SERIAL_CLOCK) disable iff (RESET)
    last_bit |=> $changed(frame_tgl_reg))
    else $error("Last bit did not commit the frame");
  c_single_write: cover property (@(posedge CORE_CLK) frame_evt && frame_load_all_n);
  c_load_all: cover property (@(posedge CORE_CLK) load_now);
  c_sleep: cover property (@(posedge CORE_CLK) pwr_reg == QDSC_SLEEP);
  c_wake: cover property (@(posedge CORE_CLK) pwr_reg == QDSC_WAKE ##1 pwr_reg == QDSC_RUN_ON);
  c_clean_skip: cover property (@(posedge CORE_CLK) load_now && !dirty_reg[0]);
endmodule : qdsc_ctrl
`default_nettype wire

// ===== verilog/qdsc_pkg.sv
// Constants and types for the quad DAC serial control block
`default_nettype none
package qdsc_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CHAN_HI_POS = 15;
  localparam int CHAN_LO_POS = 14;
  localparam int RUN_POS = 13;
  localparam int LOAD_ALL_POS = 12;
  localparam int DATA_MSB_POS = 11;
  localparam int DATA_BITS_MAX = 12;
  localparam int NUM_CHAN = 4;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic RUN_RESET = 1'b1;
  localparam int CORE_CLK_HZ = 20_000_000;
  localparam real WAKE_TIME_US = 2.5;
  localparam int WAKE_CYCLES = int'(WAKE_TIME_US * CORE_CLK_HZ / 1_000_000.0);
  typedef enum logic [1:0] {QDSC_IDLE, QDSC_WAKE, QDSC_RUN_ON, QDSC_SLEEP} qdsc_pwr_type;
endpackage : qdsc_pkg
`default_nettype wire
